// ===== cpu_regs_pkg.sv
// constants shared by the cpu register set and its flag unit
// assumes one 20 MHz clock and an AXI4-Lite debug view onto the registers
package cpu_regs_pkg;
	// bus register byte offsets
	localparam logic [5:0] accumulator_off = 6'h00;
	localparam logic [5:0] index_pair_off = 6'h04;
	localparam logic [5:0] stack_pointer_off = 6'h08;
	localparam logic [5:0] program_counter_off = 6'h0C;
	localparam logic [5:0] condition_code_reg_off = 6'h10;
	localparam logic [5:0] control_off = 6'h14;
	localparam logic [5:0] status_off = 6'h18;
	// reset values and vector addresses
	localparam logic [15:0] sp_reset = 16'h00FF;
	localparam logic [7:0] sp_low_reload = 8'hFF;
	localparam logic [15:0] reset_vector_hi_addr = 16'hFFFE;
	localparam logic [15:0] reset_vector_lo_addr = 16'hFFFF;
	// condition code bit positions
	localparam int ccr_c_pos = 0;
	localparam int ccr_z_pos = 1;
	localparam int ccr_n_pos = 2;
	localparam int ccr_i_pos = 3;
	localparam int ccr_h_pos = 4;
	localparam int ccr_v_pos = 7;
	localparam logic [7:0] ccr_fixed_ones = 8'h60;
	localparam logic [7:0] ccr_reset = 8'h68;
	// alu operation codes
	typedef enum logic [3:0] {
		alu_add = 4'h0,
		alu_adc = 4'h1,
		alu_sub = 4'h2,
		alu_and = 4'h3,
		alu_ora = 4'h4,
		alu_eor = 4'h5,
		alu_lsl = 4'h6,
		alu_lsr = 4'h7,
		alu_asr = 4'h8,
		alu_rol = 4'h9,
		alu_ror = 4'hA,
		alu_daa = 4'hB,
		alu_mov = 4'hC,
		alu_sbc = 4'hD
	} alu_op_t;
	// address source for operand fetches
	typedef enum logic [1:0] {
		addr_ix = 2'h0,
		addr_sp8 = 2'h1,
		addr_sp16 = 2'h2,
		addr_pc = 2'h3
	} addr_mode_t;
endpackage

// ===== alu_flag_if.sv
// carries operands and flag results between the register set and its flag unit
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface alu_flag_if;
	cpu_regs_pkg::alu_op_t op;
	logic [7:0] a;
	logic [7:0] b;
	logic carry_in;
	logic half_in;
	logic [7:0] result;
	logic [7:0] flags;
	modport core (output op, output a, output b, output carry_in, output half_in, input result, input flags);
	modport unit (input op, input a, input b, input carry_in, input half_in, output result, output flags);
endinterface
`default_nettype wire

// ===== cpu_alu_flags.sv
// combinational alu that produces a result byte and the v h n z c flags
// assumes the caller keeps the flags that the operation does not touch
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_flags (
	alu_flag_if.unit port_s
);
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [7:0] res;
	logic c_out;
	logic v_out;
	logic h_out;
	logic [7:0] corr;

	// result and carry out per operation
	always_comb
	begin
		sum = 9'h000;
		low_sum = 5'h00;
		res = 8'h00;
		c_out = 1'b0;
		v_out = 1'b0;
		h_out = 1'b0;
		corr = 8'h00;
		case (port_s.op)
			cpu_regs_pkg::alu_add, cpu_regs_pkg::alu_adc:
			begin
				sum = {1'b0, port_s.a} + {1'b0, port_s.b} + {8'h00, port_s.op == cpu_regs_pkg::alu_adc && port_s.carry_in};
				low_sum = {1'b0, port_s.a[3:0]} + {1'b0, port_s.b[3:0]}
					+ {4'h0, port_s.op == cpu_regs_pkg::alu_adc && port_s.carry_in};
				res = sum[7:0];
				c_out = sum[8];
				h_out = low_sum[4];
				v_out = (port_s.a[7] == port_s.b[7]) && (res[7] != port_s.a[7]);
			end
			cpu_regs_pkg::alu_sub, cpu_regs_pkg::alu_sbc:
			begin
				sum = {1'b0, port_s.a} - {1'b0, port_s.b} - {8'h00, port_s.op == cpu_regs_pkg::alu_sbc && port_s.carry_in};
				res = sum[7:0];
				c_out = sum[8]; // borrow
				v_out = (port_s.a[7] != port_s.b[7]) && (res[7] != port_s.a[7]);
			end
			cpu_regs_pkg::alu_and: res = port_s.a & port_s.b;
			cpu_regs_pkg::alu_ora: res = port_s.a | port_s.b;
			cpu_regs_pkg::alu_eor: res = port_s.a ^ port_s.b;
			cpu_regs_pkg::alu_mov: res = port_s.b;
			cpu_regs_pkg::alu_lsl, cpu_regs_pkg::alu_rol:
			begin
				res = {port_s.a[6:0], port_s.op == cpu_regs_pkg::alu_rol && port_s.carry_in};
				c_out = port_s.a[7];
				v_out = res[7] ^ c_out;
			end
			cpu_regs_pkg::alu_lsr, cpu_regs_pkg::alu_asr, cpu_regs_pkg::alu_ror:
			begin
				res = {(port_s.op == cpu_regs_pkg::alu_asr) ? port_s.a[7]
					: (port_s.op == cpu_regs_pkg::alu_ror && port_s.carry_in), port_s.a[7:1]};
				c_out = port_s.a[0];
				v_out = res[7] ^ c_out;
			end
			cpu_regs_pkg::alu_daa:
			begin
				// correction picked from half carry and carry
				if (port_s.half_in || port_s.a[3:0] > 4'h9)
					corr[3:0] = 4'h6;
				if (port_s.carry_in || port_s.a > 8'h99)
					corr[7:4] = 4'h6;
				res = port_s.a + corr;
				c_out = port_s.carry_in || port_s.a > 8'h99;
			end
			default: res = port_s.a;
		endcase
	end

	// flag byte, every affected flag cleared when its condition fails
	assign port_s.result = res;
	assign port_s.flags = {v_out, 2'b00, h_out, 1'b0, res[7], res == 8'h00, c_out};
endmodule
`default_nettype wire

// ===== cpu_register_set.sv
// programmer-visible register set of a small 8-bit cpu with an AXI4-Lite debug view
// assumes execution logic drives one-cycle strobes; memory returns read data same cycle it is asked
// Notes on behaviour
// - 8-bit accumulator holds operands and results
// - 16-bit index pair, upper and lower bytes
// - indexed modes address through the index pair
// - stack pointer resets to 00FF
// - stack reload sets low byte FF only
// - push decrements, pull increments stack pointer
// - stack modes add 8 or 16-bit offset
// - program counter increments per fetch, loads on jumps
// - reset loads program counter from FFFE/FFFF
// - condition code bits 6 and 5 read one
// - overflow flag on two's complement overflow
// - half carry from bit 3 into 4
// - decimal adjust uses half carry and carry
// - mask set blocks maskable interrupts
// - interrupt: stack registers, set mask, fetch vector
// - interrupt entry never stacks upper index byte
// - highest-priority pending request is taken first
// - interrupt return restores registers and mask
// - reset sets mask; unmask op or interrupt return clears it
// - negative flag follows result bit 7
// - zero flag when result is 00
// - carry on add carry, subtract borrow, shifts
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set #(
	parameter int irq_count = 8
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// execution strobes
	input wire logic alu_en_i,
	input wire cpu_regs_pkg::alu_op_t alu_op_i,
	input wire logic [7:0] operand_i,
	input wire logic [4:0] flag_mask_i,
	input wire logic load_ix_i,
	input wire logic [15:0] ix_value_i,
	input wire logic stack_low_byte_reload_i,
	input wire logic push_i,
	input wire logic pull_i,
	input wire logic [7:0] pull_data_i,
	input wire logic fetch_i,
	input wire logic jump_i,
	input wire logic [15:0] jump_addr_i,
	input wire logic unmask_interrupts_op_i,
	input wire logic interrupt_return_op_i,
	input wire cpu_regs_pkg::addr_mode_t addr_mode_i,
	input wire logic [15:0] offset_i,
	input wire logic [irq_count-1:0] irq_req_i,
	input wire logic [15:0] irq_vector_base_i,
	input wire logic [7:0] mem_rdata_i,
	// memory side
	output logic [15:0] mem_addr_o,
	output logic [15:0] operand_addr_o,
	output logic [7:0] push_data_o,
	output logic push_o,
	output logic busy_o,
	output logic [7:0] accumulator_o,
	output logic [7:0] condition_code_reg_o,
	// AXI4-Lite slave
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	////////////////////////////////////////////////////////////////////////////////
	// sequencer states for reset vector fetch and interrupt entry/return
	typedef enum logic [8:0] {
		st_vec_hi = 9'b000000001,
		st_vec_lo = 9'b000000010,
		st_run = 9'b000000100,
		st_push = 9'b000001000,
		st_mask = 9'b000010000,
		st_ivec_hi = 9'b000100000,
		st_ivec_lo = 9'b001000000,
		st_pull = 9'b010000000,
		st_halt = 9'b100000000
	} seq_state_t;

	seq_state_t state_reg, state_next;
	logic [7:0] accumulator_reg;
	logic [15:0] index_pair_reg;
	logic [15:0] stack_pointer_reg;
	logic [15:0] program_counter_reg;
	logic [7:0] ccr_reg;
	logic [2:0] step_reg;
	logic [15:0] vec_addr_reg;
	logic halt_reg;
	logic [7:0] wdata_lo;
	logic [7:0] alu_flags;
	logic [7:0] alu_result;
	logic [7:0] ccr_view;
	logic [7:0] ccr_from_alu;
	logic irq_take;
	logic [$clog2(irq_count)-1:0] irq_sel;
	logic [7:0] stack_byte;
	logic dbg_write;
	logic wr_acc, wr_ix, wr_sp, wr_pc, wr_ccr, wr_ctl;

	alu_flag_if flag_bus ();

	cpu_alu_flags alu_u (
		.port_s(flag_bus)
	);

	// highest index is highest priority
	function automatic logic [$clog2(irq_count)-1:0] pick_irq(input logic [irq_count-1:0] req);
		logic [$clog2(irq_count)-1:0] sel;
		sel = '0;
		for (int i = 0; i < irq_count; i++)
			if (req[i])
				sel = i[$clog2(irq_count)-1:0];
		return sel;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// alu hookup and flag merge
	assign flag_bus.op = alu_op_i;
	assign flag_bus.a = accumulator_reg;
	assign flag_bus.b = operand_i;
	assign flag_bus.carry_in = ccr_reg[cpu_regs_pkg::ccr_c_pos];
	assign flag_bus.half_in = ccr_reg[cpu_regs_pkg::ccr_h_pos];
	assign alu_result = flag_bus.result;
	assign alu_flags = flag_bus.flags;
	// only flags named in the mask (v h n z c) are touched
	assign ccr_from_alu = {
		flag_mask_i[4] ? alu_flags[7] : ccr_reg[7],
		2'b11,
		flag_mask_i[3] ? alu_flags[4] : ccr_reg[4],
		ccr_reg[3],
		flag_mask_i[2] ? alu_flags[2] : ccr_reg[2],
		flag_mask_i[1] ? alu_flags[1] : ccr_reg[1],
		flag_mask_i[0] ? alu_flags[0] : ccr_reg[0]
	};
	assign ccr_view = ccr_reg | cpu_regs_pkg::ccr_fixed_ones;

	// interrupt acceptance, blocked by mask
	assign irq_take = state_reg == st_run && !ccr_reg[cpu_regs_pkg::ccr_i_pos] && |irq_req_i && !halt_reg;
	assign irq_sel = pick_irq(irq_req_i);

	// stacking order pc low, pc high, x, a, ccr; upper index is left out
	assign stack_byte = step_reg == 3'd0 ? program_counter_reg[7:0]
		: step_reg == 3'd1 ? program_counter_reg[15:8]
		: step_reg == 3'd2 ? index_pair_reg[7:0]
		: step_reg == 3'd3 ? accumulator_reg : ccr_view;

	// operand address formation
	assign operand_addr_o = addr_mode_i == cpu_regs_pkg::addr_ix ? index_pair_reg
		: addr_mode_i == cpu_regs_pkg::addr_sp8 ? stack_pointer_reg + {8'h00, offset_i[7:0]}
		: addr_mode_i == cpu_regs_pkg::addr_sp16 ? stack_pointer_reg + offset_i : program_counter_reg;

	// memory address for the sequencer's own accesses
	assign mem_addr_o = (state_reg == st_vec_hi || state_reg == st_vec_lo || state_reg == st_ivec_hi
		|| state_reg == st_ivec_lo) ? vec_addr_reg
		: (state_reg == st_push || state_reg == st_pull || push_i || pull_i) ? stack_pointer_reg : operand_addr_o;
	assign push_o = state_reg == st_push || (state_reg == st_run && push_i);
	assign push_data_o = state_reg == st_push ? stack_byte : accumulator_reg;
	assign busy_o = state_reg != st_run || halt_reg;
	assign accumulator_o = accumulator_reg;
	assign condition_code_reg_o = ccr_view;

	////////////////////////////////////////////////////////////////////////////////
	// sequencer next state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			st_vec_hi: state_next = st_vec_lo;
			st_vec_lo: state_next = st_run;
			st_run:
			begin
				if (irq_take)
					state_next = st_push;
				else if (interrupt_return_op_i)
					state_next = st_pull;
			end
			st_push: if (step_reg == 3'd4) state_next = st_mask;
			st_mask: state_next = st_ivec_hi;
			st_ivec_hi: state_next = st_ivec_lo;
			st_ivec_lo: state_next = st_run;
			st_pull: if (step_reg == 3'd4) state_next = st_run;
			st_halt: state_next = st_run;
			default: state_next = st_vec_hi;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			state_reg <= st_vec_hi;
		else
			state_reg <= state_next;
	end

	// step counter and vector address
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			step_reg <= 3'd0;
			vec_addr_reg <= cpu_regs_pkg::reset_vector_hi_addr;
		end
		else
		begin
			step_reg <= (state_reg == st_push || state_reg == st_pull) && step_reg != 3'd4 ? step_reg + 3'd1 : 3'd0;
			if (state_reg == st_vec_hi)
				vec_addr_reg <= cpu_regs_pkg::reset_vector_lo_addr;
			else if (state_reg == st_mask)
				vec_addr_reg <= irq_vector_base_i - 16'({irq_sel, 1'b0}); // two bytes per vector slot
			else if (state_reg == st_ivec_hi)
				vec_addr_reg <= vec_addr_reg + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus write decode
	assign dbg_write = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign wdata_lo = s_axi_wdata[7:0];
	assign wr_acc = dbg_write && s_axi_awaddr == cpu_regs_pkg::accumulator_off;
	assign wr_ix = dbg_write && s_axi_awaddr == cpu_regs_pkg::index_pair_off;
	assign wr_sp = dbg_write && s_axi_awaddr == cpu_regs_pkg::stack_pointer_off;
	assign wr_pc = dbg_write && s_axi_awaddr == cpu_regs_pkg::program_counter_off;
	assign wr_ccr = dbg_write && s_axi_awaddr == cpu_regs_pkg::condition_code_reg_off;
	assign wr_ctl = dbg_write && s_axi_awaddr == cpu_regs_pkg::control_off && s_axi_wstrb[0];

	// accumulator and index pair
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			accumulator_reg <= 8'h00;
			index_pair_reg <= 16'h0000;
		end
		else if (wr_acc && s_axi_wstrb[0])
			accumulator_reg <= wdata_lo;
		else if (wr_ix)
			index_pair_reg <= {s_axi_wstrb[1] ? s_axi_wdata[15:8] : index_pair_reg[15:8],
				s_axi_wstrb[0] ? wdata_lo : index_pair_reg[7:0]};
		else if (state_reg == st_pull && step_reg == 3'd1)
			accumulator_reg <= pull_data_i;
		else if (state_reg == st_pull && step_reg == 3'd2)
			index_pair_reg[7:0] <= pull_data_i;
		else if (state_reg == st_run && alu_en_i)
			accumulator_reg <= alu_result;
		else if (state_reg == st_run && load_ix_i)
			index_pair_reg <= ix_value_i;
	end

	// stack pointer
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			stack_pointer_reg <= cpu_regs_pkg::sp_reset;
		else if (wr_sp)
			stack_pointer_reg <= s_axi_wdata[15:0];
		else if (state_reg == st_push || (state_reg == st_run && push_i))
			stack_pointer_reg <= stack_pointer_reg - 16'h0001;
		else if (state_reg == st_pull || (state_reg == st_run && pull_i))
			stack_pointer_reg <= stack_pointer_reg + 16'h0001;
		else if (state_reg == st_run && stack_low_byte_reload_i)
			stack_pointer_reg[7:0] <= cpu_regs_pkg::sp_low_reload;
	end

	// program counter
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			program_counter_reg <= 16'h0000;
		else if (state_reg == st_vec_hi || state_reg == st_ivec_hi)
			program_counter_reg[15:8] <= mem_rdata_i;
		else if (state_reg == st_vec_lo || state_reg == st_ivec_lo)
			program_counter_reg[7:0] <= mem_rdata_i;
		else if (state_reg == st_pull && step_reg == 3'd3)
			program_counter_reg[15:8] <= pull_data_i;
		else if (state_reg == st_pull && step_reg == 3'd4)
			program_counter_reg[7:0] <= pull_data_i;
		else if (wr_pc)
			program_counter_reg <= s_axi_wdata[15:0];
		else if (state_reg == st_run && jump_i)
			program_counter_reg <= jump_addr_i;
		else if (state_reg == st_run && fetch_i)
			program_counter_reg <= program_counter_reg + 16'h0001;
	end

	// condition codes; mask set at reset and on entry
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			ccr_reg <= cpu_regs_pkg::ccr_reset;
		else if (state_reg == st_mask)
			ccr_reg[cpu_regs_pkg::ccr_i_pos] <= 1'b1;
		else if (state_reg == st_pull && step_reg == 3'd0)
			ccr_reg <= pull_data_i | cpu_regs_pkg::ccr_fixed_ones;
		else if (wr_ccr && s_axi_wstrb[0])
			ccr_reg <= {wdata_lo[7], 2'b11, wdata_lo[4], ccr_reg[3], wdata_lo[2:0]};
		else if (state_reg == st_run && alu_en_i)
			ccr_reg <= ccr_from_alu;
		else if (state_reg == st_run && unmask_interrupts_op_i)
			ccr_reg[cpu_regs_pkg::ccr_i_pos] <= 1'b0;
	end

	// debug halt control
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			halt_reg <= 1'b0;
		else if (wr_ctl)
			halt_reg <= wdata_lo[0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite handshakes: write taken when both channels present
	assign s_axi_awready = dbg_write;
	assign s_axi_wready = dbg_write;
	assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else if (dbg_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= s_axi_awaddr > cpu_regs_pkg::status_off || s_axi_awaddr[1:0] != 2'b00
				? 2'b10 : 2'b00;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read data mux
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end
		else if (s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (s_axi_araddr)
				cpu_regs_pkg::accumulator_off: s_axi_rdata <= {24'h000000, accumulator_reg};
				cpu_regs_pkg::index_pair_off: s_axi_rdata <= {16'h0000, index_pair_reg};
				cpu_regs_pkg::stack_pointer_off: s_axi_rdata <= {16'h0000, stack_pointer_reg};
				cpu_regs_pkg::program_counter_off: s_axi_rdata <= {16'h0000, program_counter_reg};
				cpu_regs_pkg::condition_code_reg_off: s_axi_rdata <= {24'h000000, ccr_view};
				cpu_regs_pkg::control_off: s_axi_rdata <= {31'h00000000, halt_reg};
				cpu_regs_pkg::status_off: s_axi_rdata <= {23'h000000, state_reg};
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule
`default_nettype wire

// ===== cpu_register_set_asserts.sv
// concurrent checks on the cpu register set top-level ports
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set_asserts #(
	parameter int irq_count = 8
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic alu_en_i,
	input wire logic [4:0] flag_mask_i,
	input wire logic push_i,
	input wire logic unmask_interrupts_op_i,
	input wire logic [irq_count-1:0] irq_req_i,
	input wire logic [15:0] mem_addr_o,
	input wire logic push_o,
	input wire logic busy_o,
	input wire logic [7:0] accumulator_o,
	input wire logic [7:0] condition_code_reg_o
);
	wire logic [7:0] cc = condition_code_reg_o;
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	// boot vector fetch, interrupt take and entry steps
	sequence s_boot;
		mem_addr_o == 16'hFFFE ##1 mem_addr_o == 16'hFFFF ##1 !busy_o;
	endsequence
	sequence s_take;
		!busy_o && !cc[3] && (|irq_req_i);
	endsequence
	sequence s_entry;
		push_o [*5] ##1 (!push_o && !cc[3]) ##1 (cc[3] && busy_o);
	endsequence
	AST_BOOT_SEQ: assert property ($fell(rst_i) |-> s_boot)
		else $error("reset vector fetch order wrong");
	AST_CCR_RESET: assert property ($fell(rst_i) |-> cc == 8'h68)
		else $error("condition codes wrong after reset");
	AST_FIXED_ONES: assert property (cc[6:5] == 2'h3)
		else $error("fixed condition code bits not one");
	AST_ZERO_FLAG: assert property (alu_en_i && flag_mask_i[1] && !busy_o |=> cc[1] == (accumulator_o == 8'h00))
		else $error("zero flag does not follow result");
	AST_NEG_FLAG: assert property (alu_en_i && flag_mask_i[2] && !busy_o |=> cc[2] == accumulator_o[7])
		else $error("negative flag does not follow result");
	AST_MASK_BLOCKS: assert property (cc[3] && !push_i |-> !push_o)
		else $error("stack write while interrupts masked");
	AST_IRQ_ENTRY: assert property (s_take |=> s_entry)
		else $error("interrupt entry steps wrong");
	AST_MASK_CLEAR: assert property ($fell(cc[3]) |-> $past(unmask_interrupts_op_i) || $past(busy_o))
		else $error("mask cleared without unmask or return");
endmodule
bind cpu_register_set cpu_register_set_asserts #(.irq_count(irq_count)) u_cpu_register_set_asserts (
	.clk_sys_i, .rst_i, .alu_en_i, .flag_mask_i, .push_i, .unmask_interrupts_op_i, .irq_req_i,
	.mem_addr_o, .push_o, .busy_o, .accumulator_o, .condition_code_reg_o);
`default_nettype wire

// ===== tb_cpu_register_set.sv
// self-checking bench for the cpu register set with an integer model
// assumes the package offsets and a combinational memory behind mem_addr_o
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_register_set;
	localparam int ic = 8;
	localparam logic [5:0] ra = cpu_regs_pkg::accumulator_off;
	localparam logic [5:0] rx = cpu_regs_pkg::index_pair_off;
	localparam logic [5:0] rs = cpu_regs_pkg::stack_pointer_off;
	localparam logic [5:0] rp = cpu_regs_pkg::program_counter_off;
	localparam logic [5:0] rc = cpu_regs_pkg::condition_code_reg_off;
	logic clk_sys_i = 1'b0, rst_i = 1'b1;
	logic [8:0] strb = '0;
	wire logic alu_en_i, load_ix_i, stack_low_byte_reload_i, push_i, pull_i, fetch_i, jump_i;
	wire logic unmask_interrupts_op_i, interrupt_return_op_i;
	cpu_regs_pkg::alu_op_t alu_op_i = cpu_regs_pkg::alu_add;
	cpu_regs_pkg::addr_mode_t addr_mode_i = cpu_regs_pkg::addr_ix;
	logic [7:0] operand_i = '0, pull_data_i = 8'hA0, mem_rdata_i, accumulator_o, condition_code_reg_o, push_data_o;
	logic [4:0] flag_mask_i = '0;
	logic [15:0] ix_value_i = '0, jump_addr_i = '0, offset_i = '0, irq_vector_base_i = 16'hFFFC;
	logic [15:0] mem_addr_o, operand_addr_o;
	logic [ic-1:0] irq_req_i = '0;
	logic push_o, busy_o, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	int bad_count = 0, checks_done = 0, m_a, m_cc, m_sp, m_pc, m_ix, n;
	int da[3] = '{8'h15, 8'h19, 8'h99}, db[3] = '{8'h27, 8'h28, 8'h01}, de[3] = '{8'h42, 8'h47, 8'h00};
	logic [5:0] ua[2] = '{6'h1C, 6'h02};
	logic [7:0] pq[$];
	logic [7:0] eq[5];
	assign {alu_en_i, load_ix_i, stack_low_byte_reload_i, push_i, pull_i, fetch_i, jump_i,
		unmask_interrupts_op_i, interrupt_return_op_i} = strb;
	assign mem_rdata_i = mem_addr_o[7:0] + 8'h35;
	cpu_register_set #(.irq_count(ic)) u_cpu_register_set (.*);
	initial
	begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	// stack writes seen on the memory side
	always @(negedge clk_sys_i)
	begin
		if (push_o === 1'b1)
			pq.push_back(push_data_o);
	end
	////////////////////////////////////////////////////////////////
	function automatic int mb(input int a);
		return (a + 8'h35) & 255;
	endfunction
	task automatic summarize();
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask
	task automatic guard();
		n++;
		if (n > 300)
		begin
			$display("unexpected wait expected %0d seen %0d", 300, n);
			bad_count++;
			summarize();
		end
	endtask
	task automatic waitb(input logic lv);
		n = 0;
		do
		begin
			@(negedge clk_sys_i);
			guard();
		end
		while (busy_o !== lv);
	endtask
	// one AXI4-Lite write or read, held until each ready or valid is seen
	task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		n = 0;
		do
		begin
			@(negedge clk_sys_i);
			guard();
		end
		while ((w ? s_axi_awready && s_axi_wready : s_axi_arready) !== 1'b1);
		@(posedge clk_sys_i);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_arvalid <= 1'b0;
		n = 0;
		do
		begin
			@(negedge clk_sys_i);
			guard();
		end
		while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
		rd = s_axi_rdata;
		rr = w ? s_axi_bresp : s_axi_rresp;
		@(posedge clk_sys_i);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk(nm, e, rd);
	endtask
	task automatic pulse(input logic [8:0] s);
		@(posedge clk_sys_i);
		strb <= s;
		@(posedge clk_sys_i);
		strb <= '0;
	endtask
	// alu strobe plus the flag model for add, adc, sub and and
	task automatic op_run(input int op, input int b, input logic [4:0] mk);
		int r, c, v, h, f, mm;
		alu_op_i <= cpu_regs_pkg::alu_op_t'(op);
		operand_i <= 8'(b);
		flag_mask_i <= mk;
		pulse(9'h100);
		c = op == 1 ? m_cc & 1 : 0;
		r = op == 3 ? m_a & b : op == 2 ? m_a - b : m_a + b + c;
		h = ((m_a & 15) + (b & 15) + c) > 15;
		c = op == 2 ? m_a < b : r > 255;
		v = op == 3 ? 0 : (((op == 2 ? m_a : ~m_a) ^ b) & (m_a ^ r) & 128) != 0;
		r = r & 255;
		f = (v << 7) | (h << 4) | ((r >> 7) << 2) | ((r == 0) << 1) | c;
		mm = (mk[4] << 7) | (mk[3] << 4) | (mk[2] << 2) | (mk[1] << 1) | mk[0];
		if (op < 4)
		begin
			m_cc = (m_cc & ~mm) | (f & mm);
			m_a = r;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'hA9A0));
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		waitb(1'b0);
		m_pc = (mb(16'hFFFE) << 8) | mb(16'hFFFF);
		rdchk("sp", rs, 32'h00FF);
		rdchk("ccr", rc, 32'h68);
		rdchk("pc", rp, m_pc);
		repeat (3) pulse(9'h008);
		rdchk("pc", rp, m_pc + 3);
		m_pc = $urandom % 65536;
		jump_addr_i <= 16'(m_pc);
		pulse(9'h00C);
		rdchk("pc", rp, m_pc);
		repeat (3) pulse(9'h020);
		pulse(9'h010);
		rdchk("sp", rs, 32'h00FD);
		bus(1, rs, 32'h1234);
		pulse(9'h040);
		m_sp = 32'h12FF;
		rdchk("sp", rs, m_sp);
		m_ix = $urandom % 65536;
		ix_value_i <= 16'(m_ix);
		offset_i <= 16'($urandom);
		pulse(9'h080);
		rdchk("ix", rx, m_ix);
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk_sys_i);
			addr_mode_i <= cpu_regs_pkg::addr_mode_t'(k);
			@(negedge clk_sys_i);
			chk("oaddr", k == 0 ? m_ix : (m_sp + (k == 1 ? offset_i[7:0] : offset_i)) & 65535, operand_addr_o);
		end
		bus(1, rc, 32'h0);
		m_cc = 8'h68;
		rdchk("ccr", rc, m_cc);
		foreach (ua[k])
		begin
			bus(0, ua[k], 0);
			chk("rresp", 2'h2, rr);
			chk("rdata", 0, rd);
		end
		bus(1, cpu_regs_pkg::status_off, 32'hF);
		chk("bresp", 2'h0, rr);
		for (int i = 0; i < 12; i++)
		begin
			m_a = $urandom % 256;
			bus(1, ra, m_a);
			op_run(i % 4, $urandom % 256, i % 4 == 3 ? 5'h16 : i % 4 == 2 ? 5'h17 : 5'h1F);
			rdchk("acc", ra, m_a);
			rdchk("ccr", rc, m_cc);
			chk("acc_o", m_a, accumulator_o);
			chk("ccr_o", m_cc, condition_code_reg_o);
		end
		for (int k = 0; k < 3; k++)
		begin
			m_a = da[k];
			bus(1, ra, m_a);
			op_run(0, db[k], 5'h1F);
			op_run(cpu_regs_pkg::alu_daa, 0, 5'h00);
			m_a = de[k];
			rdchk("daa", ra, m_a);
		end
		pulse(9'h002);
		m_cc = m_cc & 8'hF7;
		rdchk("ccr", rc, m_cc);
		pq.delete();
		eq = '{8'(m_pc), 8'(m_pc >> 8), 8'(m_ix), 8'(m_a), 8'(m_cc)};
		irq_req_i <= 8'h05;
		waitb(1'b1);
		waitb(1'b0);
		repeat (20) @(posedge clk_sys_i);
		chk("pushes", 5, pq.size());
		foreach (eq[k])
			chk("push", eq[k], pq[k]);
		irq_req_i <= '0;
		m_pc = (mb(16'hFFF8) << 8) | mb(16'hFFF9);
		rdchk("pc", rp, m_pc);
		rdchk("ccr", rc, m_cc | 8);
		rdchk("sp", rs, m_sp - 5);
		pulse(9'h001);
		waitb(1'b1);
		waitb(1'b0);
		rdchk("ccr", rc, 32'hE0);
		rdchk("acc", ra, 32'hA0);
		rdchk("pc", rp, 32'hA0A0);
		rdchk("sp", rs, m_sp);
		summarize();
	end
endmodule
`default_nettype wire
